// [core/spi_image_cfg.svh]
/*
  Constants of the splitter process image: block bounds, word offsets
  within the box's slot, channel count and reset values.
  Assumes inclusion by the image module only.
*/
`ifndef SPI_IMAGE_CFG_SVH
`define SPI_IMAGE_CFG_SVH

`define SPI_OUT_BLOCK_FIRST 16'h9c41
`define SPI_OUT_BLOCK_LAST  16'hac40
`define SPI_IN_BLOCK_FIRST  16'hb150
`define SPI_IN_BLOCK_LAST   16'hc14f
`define SPI_BLOCK_WORDS     16'h1000

`define SPI_IN_WORDS        16'h0008
`define SPI_OUT_WORDS       16'h0002

`define SPI_IN_PIN4_STATE   3'h0
`define SPI_IN_PIN2_DATA    3'h1
`define SPI_IN_COMMON_DIAG  3'h2
`define SPI_IN_SUPPLY_SHORT 3'h3
`define SPI_IN_PIN4_SHORT   3'h4
`define SPI_IN_PIN2_SHORT   3'h5
`define SPI_IN_PIN4_WARN    3'h6
`define SPI_IN_PIN2_WARN    3'h7

`define SPI_OUT_PIN4_CMD    1'h0
`define SPI_OUT_PIN2_CMD    1'h1

`define SPI_CHANNELS        8
`define SPI_CMD_RESET       16'h0000

`endif

// [core/spi_image_map.sv]
/*
  Process image of an eight-channel splitter box: eight read-only input
  words and two writable output command words inside the island
  interface module's image blocks, at slots chosen by that module.
  Assumes field signals arrive asynchronously and are synchronised here;
  channel configuration and slot bases come from logic on core_clk.
*/
// Behaviour
// - Two adjacent output command words inside output block 40001 to 44096.
// - Eight adjacent input words in block from 45392, data before diagnostics.
// - Word 1 carries pin-4 inputs; output-configured pin 4 bits unused.
// - Pin 2 gives diagnostics by default; none once pin 2 is I/O.
// - Word 2 carries pin-2 diagnostic or input state per configuration.
// - Diagnostic pin 2 reports 1 and red light without signal, else 0.
// - Word 3 holds common diagnostic flags, 1 meaning a problem.
// - Word 4 flags sensor supply shorts, one bit per channel.
// - Word 5 flags pin-4 actuator shorts; input pin 4 bits unused.
// - Word 6 flags pin-2 actuator shorts; input or diagnostic bits unused.
// - Word 7 flags pin-4 actuator warnings; input pin 4 bits unused.
// - Word 8 flags pin-2 actuator warnings; input or diagnostic bits unused.
// - Output word 1 commands pin-4 actuators; input pin 4 bits ignored.
// - Output word 2 commands pin-2 actuators; input or diagnostic bits ignored.
`include "spi_image_cfg.svh"

module spi_image_map #(
  parameter int CHANNELS = `SPI_CHANNELS
) (
  input  wire logic                   core_clk,        // 25 MHz clock
  input  wire logic                   sys_rst,         // Sync reset, active high
  input  wire logic [15:0]            in_slot_base,    // First input word number
  input  wire logic [15:0]            out_slot_base,   // First output word number
  input  wire logic [CHANNELS-1:0]    pin4_is_output,  // 1: pin 4 drives actuator
  input  wire logic [CHANNELS-1:0]    pin2_diag_en,    // 1: pin 2 reports diagnostics
  input  wire logic [CHANNELS-1:0]    pin2_is_output,  // 1 with pin2_diag_en 0: pin 2 drives actuator
  input  wire logic [CHANNELS-1:0]    pin4_level,      // Pin 4 sensor level
  input  wire logic [CHANNELS-1:0]    pin2_level,      // Pin 2 signal level
  input  wire logic [15:0]            common_fault,    // Common diagnostic flags
  input  wire logic [CHANNELS-1:0]    supply_short,    // Sensor supply short
  input  wire logic [CHANNELS-1:0]    pin4_short,      // Pin 4 actuator short
  input  wire logic [CHANNELS-1:0]    pin2_short,      // Pin 2 actuator short
  input  wire logic [CHANNELS-1:0]    pin4_warn,       // Pin 4 actuator warning
  input  wire logic [CHANNELS-1:0]    pin2_warn,       // Pin 2 actuator warning
  input  wire logic                   rd_en,           // Read strobe
  input  wire logic [15:0]            rd_addr,         // Word number to read
  output logic      [15:0]            rd_data,         // Read word, registered
  output logic                        rd_valid,        // One-cycle read answer
  output logic                        rd_hit,          // Address was ours
  input  wire logic                   wr_en,           // Write strobe
  input  wire logic [15:0]            wr_addr,         // Word number to write
  input  wire logic [15:0]            wr_data,         // Word to write
  output logic                        slot_ok,         // Slots lie inside blocks
  output logic      [CHANNELS-1:0]    pin4_drive,      // Pin 4 actuator drive
  output logic      [CHANNELS-1:0]    pin2_drive,      // Pin 2 actuator drive
  output logic      [CHANNELS-1:0]    red_led          // Red indicator per socket
);

  if (CHANNELS < 1 || CHANNELS > 16) begin : g_bad_channels
    $error("CHANNELS must lie in 1..16");
  end

  localparam int NF = 7 * CHANNELS + 16;

  function automatic spi_image_pkg::spi_pin2_mode_e pin2_mode(input logic diag,
                                                              input logic outp);
    if (diag) begin
      return spi_image_pkg::SPI_PIN2_DIAG;
    end else if (outp) begin
      return spi_image_pkg::SPI_PIN2_OUTPUT;
    end
    return spi_image_pkg::SPI_PIN2_INPUT;
  endfunction : pin2_mode

  function automatic logic [15:0] widen(input logic [CHANNELS-1:0] v);
    logic [15:0] w;
    w = 16'h0000;
    w[CHANNELS-1:0] = v;
    return w;
  endfunction : widen

  // Field signals through two flip-flops
  logic [NF-1:0] field_meta_reg;
  logic [NF-1:0] field_sync_reg;
  always_ff @(posedge core_clk) begin
    field_meta_reg <= {pin4_level, pin2_level, common_fault, supply_short,
                       pin4_short, pin2_short, pin4_warn, pin2_warn};
    field_sync_reg <= field_meta_reg;
  end

  logic [CHANNELS-1:0] s_p4lvl;
  logic [CHANNELS-1:0] s_p2lvl;
  logic [15:0]         s_common;
  logic [CHANNELS-1:0] s_supply;
  logic [CHANNELS-1:0] s_p4sh;
  logic [CHANNELS-1:0] s_p2sh;
  logic [CHANNELS-1:0] s_p4wr;
  logic [CHANNELS-1:0] s_p2wr;
  assign {s_p4lvl, s_p2lvl, s_common, s_supply, s_p4sh, s_p2sh, s_p4wr, s_p2wr} =
         field_sync_reg;

  // Per-socket mode masks
  logic [CHANNELS-1:0] p2_diag_m;
  logic [CHANNELS-1:0] p2_in_m;
  logic [CHANNELS-1:0] p2_out_m;
  always_comb begin
    for (int i = 0; i < CHANNELS; i++) begin
      p2_diag_m[i] = 1'b0;
      p2_in_m[i]   = 1'b0;
      p2_out_m[i]  = 1'b0;
      unique case (pin2_mode(pin2_diag_en[i], pin2_is_output[i]))
        spi_image_pkg::SPI_PIN2_DIAG:   p2_diag_m[i] = 1'b1;
        spi_image_pkg::SPI_PIN2_INPUT:  p2_in_m[i]   = 1'b1;
        spi_image_pkg::SPI_PIN2_OUTPUT: p2_out_m[i]  = 1'b1;
      endcase
    end
  end

  // Input image words
  spi_image_pkg::spi_word_t in_word [8];
  always_comb begin
    in_word[`SPI_IN_PIN4_STATE]   = widen(s_p4lvl & ~pin4_is_output);
    in_word[`SPI_IN_PIN2_DATA]    = widen((~s_p2lvl & p2_diag_m)
                                          | (s_p2lvl & p2_in_m));
    in_word[`SPI_IN_COMMON_DIAG]  = s_common;
    in_word[`SPI_IN_SUPPLY_SHORT] = widen(s_supply);
    in_word[`SPI_IN_PIN4_SHORT]   = widen(s_p4sh & pin4_is_output);
    in_word[`SPI_IN_PIN2_SHORT]   = widen(s_p2sh & p2_out_m);
    in_word[`SPI_IN_PIN4_WARN]    = widen(s_p4wr & pin4_is_output);
    in_word[`SPI_IN_PIN2_WARN]    = widen(s_p2wr & p2_out_m);
  end

  // Slot placement inside the two blocks
  logic [16:0] in_last;
  logic [16:0] out_last;
  assign in_last  = {1'b0, in_slot_base} + {1'b0, `SPI_IN_WORDS} - 17'h00001;
  assign out_last = {1'b0, out_slot_base} + {1'b0, `SPI_OUT_WORDS} - 17'h00001;
  assign slot_ok  = (in_slot_base >= `SPI_IN_BLOCK_FIRST)
                 && (in_last <= {1'b0, `SPI_IN_BLOCK_LAST})
                 && (out_slot_base >= `SPI_OUT_BLOCK_FIRST)
                 && (out_last <= {1'b0, `SPI_OUT_BLOCK_LAST});

  function automatic logic in_slot(input logic [15:0] a, input logic [15:0] base);
    return (a >= base) && ({1'b0, a} <= ({1'b0, base} + {1'b0, `SPI_IN_WORDS}
                                         - 17'h00001));
  endfunction : in_slot

  function automatic logic out_slot(input logic [15:0] a, input logic [15:0] base);
    return (a == base) || (a == base + 16'h0001);
  endfunction : out_slot

  logic [15:0] rd_off;
  logic [15:0] wr_off;
  logic        rd_in_hit;
  logic        rd_out_hit;
  logic        wr_out_hit;
  assign rd_off     = rd_addr - in_slot_base;
  assign wr_off     = wr_addr - out_slot_base;
  assign rd_in_hit  = slot_ok && in_slot(rd_addr, in_slot_base);
  assign rd_out_hit = slot_ok && out_slot(rd_addr, out_slot_base);
  assign wr_out_hit = slot_ok && wr_en && out_slot(wr_addr, out_slot_base);

  // Output command words, readable back
  spi_image_pkg::spi_word_t cmd_reg [2];
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      cmd_reg[0] <= `SPI_CMD_RESET;
      cmd_reg[1] <= `SPI_CMD_RESET;
    end else if (wr_out_hit) begin
      cmd_reg[wr_off[0]] <= wr_data;
    end
  end

  // Read answer one cycle after the strobe
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      rd_data  <= 16'h0000;
      rd_valid <= 1'b0;
      rd_hit   <= 1'b0;
    end else begin
      rd_valid <= rd_en;
      rd_hit   <= rd_en && (rd_in_hit || rd_out_hit);
      if (rd_en && rd_in_hit) begin
        rd_data <= in_word[rd_off[2:0]];
      end else if (rd_en && rd_out_hit) begin
        rd_data <= cmd_reg[rd_addr[0] ^ out_slot_base[0]];
      end else if (rd_en) begin
        rd_data <= 16'h0000;
      end
    end
  end

  // Actuator drives and indicators
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      pin4_drive <= '0;
      pin2_drive <= '0;
      red_led    <= '0;
    end else begin
      pin4_drive <= cmd_reg[`SPI_OUT_PIN4_CMD][CHANNELS-1:0] & pin4_is_output;
      pin2_drive <= cmd_reg[`SPI_OUT_PIN2_CMD][CHANNELS-1:0] & p2_out_m;
      red_led    <= ~s_p2lvl & p2_diag_m;
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  property p_pin4_ignore;
    ##1 1'b1 |-> (pin4_drive & ~$past(pin4_is_output)) == '0;
  endproperty
  a_pin4_ignore: assert property (p_pin4_ignore) else $error("pin 4 input driven");

  property p_pin2_ignore;
    ##1 1'b1 |-> (pin2_drive & ($past(pin2_diag_en) | ~$past(pin2_is_output))) == '0;
  endproperty
  a_pin2_ignore: assert property (p_pin2_ignore) else $error("pin 2 non-output driven");

  property p_write_drives;
    wr_en && slot_ok && wr_addr == out_slot_base && $stable(pin4_is_output) [*1]
    ##1 $stable(pin4_is_output)
    |=> pin4_drive == ($past(wr_data[CHANNELS-1:0], 2) & $past(pin4_is_output, 2));
  endproperty
  a_write_drives: assert property (p_write_drives) else $error("pin 4 command lost");

  property p_read_timing;
    rd_en |=> rd_valid;
  endproperty
  a_read_timing: assert property (p_read_timing) else $error("read answer late");

  property p_unmapped_zero;
    rd_en && !(rd_in_hit || rd_out_hit) |=> !rd_hit && rd_data == 16'h0000;
  endproperty
  a_unmapped_zero: assert property (p_unmapped_zero) else $error("unmapped read not zero");

  property p_upper_zero;
    rd_en && rd_in_hit && rd_off[2:0] != `SPI_IN_COMMON_DIAG
    |=> rd_hit && (rd_data >> CHANNELS) == 16'h0000;
  endproperty
  a_upper_zero: assert property (p_upper_zero) else $error("unused input bits set");

  property p_pin4_state;
    rd_en && rd_in_hit && rd_off[2:0] == `SPI_IN_PIN4_STATE
    |=> (rd_data[CHANNELS-1:0] & $past(pin4_is_output)) == '0;
  endproperty
  a_pin4_state: assert property (p_pin4_state) else $error("pin 4 output bit reported");

  property p_led_diag;
    ##1 1'b1 |-> (red_led & ~$past(pin2_diag_en)) == '0;
  endproperty
  a_led_diag: assert property (p_led_diag) else $error("led lit outside diag mode");

  property p_short_mask;
    rd_en && rd_in_hit && rd_off[2:0] == `SPI_IN_PIN2_SHORT
    |=> (rd_data[CHANNELS-1:0] & ($past(pin2_diag_en) | ~$past(pin2_is_output))) == '0;
  endproperty
  a_short_mask: assert property (p_short_mask) else $error("pin 2 short bit unused set");

  property p_supply_word;
    rd_en && rd_in_hit && rd_off[2:0] == `SPI_IN_SUPPLY_SHORT
    |=> rd_data[CHANNELS-1:0] == $past(field_sync_reg[4*CHANNELS +: CHANNELS]);
  endproperty
  a_supply_word: assert property (p_supply_word) else $error("supply short word wrong");

  property p_p4_short;
    rd_en && rd_in_hit && rd_off[2:0] == `SPI_IN_PIN4_SHORT
    |=> (rd_data[CHANNELS-1:0] & ~$past(pin4_is_output)) == '0;
  endproperty
  a_p4_short: assert property (p_p4_short) else $error("pin 4 short unused set");

  property p_p4_warn;
    rd_en && rd_in_hit && rd_off[2:0] == `SPI_IN_PIN4_WARN
    |=> (rd_data[CHANNELS-1:0] & ~$past(pin4_is_output)) == '0;
  endproperty
  a_p4_warn: assert property (p_p4_warn) else $error("pin 4 warning unused set");

  property p_p2_warn;
    rd_en && rd_in_hit && rd_off[2:0] == `SPI_IN_PIN2_WARN
    |=> (rd_data[CHANNELS-1:0] & ($past(pin2_diag_en) | ~$past(pin2_is_output))) == '0;
  endproperty
  a_p2_warn: assert property (p_p2_warn) else $error("pin 2 warning unused set");

  property p_p2_diag;
    rd_en && rd_in_hit && rd_off[2:0] == `SPI_IN_PIN2_DATA
    |=> (rd_data[CHANNELS-1:0] & $past(pin2_diag_en)) == $past(~s_p2lvl & pin2_diag_en);
  endproperty
  a_p2_diag: assert property (p_p2_diag) else $error("pin 2 diag bit wrong");

  property p_common;
    rd_en && rd_in_hit && rd_off[2:0] == `SPI_IN_COMMON_DIAG
    |=> rd_data == $past(s_common);
  endproperty
  a_common: assert property (p_common) else $error("common word wrong");

  property p_ro_words;
    wr_en && wr_addr != out_slot_base && wr_addr != out_slot_base + 16'h0001
    |=> $stable(cmd_reg[0]) && $stable(cmd_reg[1]);
  endproperty
  a_ro_words: assert property (p_ro_words) else $error("foreign write landed");

  property p_read_pulse;
    !rd_en |=> !rd_valid;
  endproperty
  a_read_pulse: assert property (p_read_pulse) else $error("read answer unasked");

endmodule : spi_image_map

// [core/spi_image_pkg.sv]
/*
  Types of the splitter process image.
  Assumes spi_image_cfg.svh for the numeric constants.
*/
package spi_image_pkg;
  typedef logic [15:0] spi_word_t;
  typedef enum logic [1:0] {
    SPI_PIN2_DIAG,
    SPI_PIN2_INPUT,
    SPI_PIN2_OUTPUT
  } spi_pin2_mode_e;
endpackage : spi_image_pkg

// [dv/spi_image_map_tb_top.sv]
/*
  Self-checking bench of the splitter process image.
  Assumes spi_nim_model as the interface module side.
*/
module spi_image_map_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        core_clk = 1'b0;
  logic        sys_rst  = 1'b1;
  logic [15:0] in_slot_base, out_slot_base, rd_addr, rd_data, wr_addr, wr_data, d;
  logic        rd_en, rd_valid, rd_hit, wr_en, slot_ok;
  logic [15:0] common_fault;
  logic [7:0]  pin4_is_output, pin2_diag_en, pin2_is_output, pin4_level, pin2_level;
  logic [7:0]  supply_short, pin4_short, pin2_short, pin4_warn, pin2_warn;
  logic [7:0]  pin4_drive, pin2_drive, red_led;
  logic [1:0]  vh;
  logic [15:0] wv;
  logic [95:0] tab [3] = '{{24'h00ff00, 72'ha55a000000ff00ff00},
                           {24'h0f3346, 72'ha596800181ffff3cff},
                           {24'hff00ff, 72'h3cc37ffe7e55aa0ff0}};
  int          fails = 0;
  int          check_count = 0;
  always #20 core_clk = ~core_clk;
  initial {pin4_is_output, pin2_diag_en, pin2_is_output} = 24'h00ff00;
  initial {pin4_level, pin2_level, common_fault, supply_short, pin4_short,
           pin2_short, pin4_warn, pin2_warn} = '0;
  spi_image_map u_dut (.core_clk(core_clk), .sys_rst(sys_rst), .in_slot_base(in_slot_base),
    .out_slot_base(out_slot_base), .pin4_is_output(pin4_is_output),
    .pin2_diag_en(pin2_diag_en), .pin2_is_output(pin2_is_output), .pin4_level(pin4_level),
    .pin2_level(pin2_level), .common_fault(common_fault), .supply_short(supply_short),
    .pin4_short(pin4_short), .pin2_short(pin2_short), .pin4_warn(pin4_warn),
    .pin2_warn(pin2_warn), .rd_en(rd_en), .rd_addr(rd_addr), .rd_data(rd_data),
    .rd_valid(rd_valid), .rd_hit(rd_hit), .wr_en(wr_en), .wr_addr(wr_addr),
    .wr_data(wr_data), .slot_ok(slot_ok), .pin4_drive(pin4_drive),
    .pin2_drive(pin2_drive), .red_led(red_led));
  spi_nim_model u_nim (.core_clk(core_clk), .in_slot_base(in_slot_base),
    .out_slot_base(out_slot_base), .rd_en(rd_en), .rd_addr(rd_addr), .rd_data(rd_data),
    .rd_valid(rd_valid), .rd_hit(rd_hit), .wr_en(wr_en), .wr_addr(wr_addr),
    .wr_data(wr_data));
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic stop_test;
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : stop_test
  function automatic logic [15:0] exp_in(input int i);
    logic [7:0] p2o;
    logic [7:0] p2i;
    p2o = pin2_is_output & ~pin2_diag_en;
    p2i = ~pin2_is_output & ~pin2_diag_en;
    case (i)
      0: exp_in = {8'h00, pin4_level & ~pin4_is_output};
      1: exp_in = {8'h00, (~pin2_level & pin2_diag_en) | (pin2_level & p2i)};
      2: exp_in = common_fault;
      3: exp_in = {8'h00, supply_short};
      4: exp_in = {8'h00, pin4_short & pin4_is_output};
      5: exp_in = {8'h00, pin2_short & p2o};
      6: exp_in = {8'h00, pin4_warn & pin4_is_output};
      default: exp_in = {8'h00, pin2_warn & p2o};
    endcase
  endfunction : exp_in
  task automatic check_cmds(input logic [15:0] w0, input logic [15:0] w1);
    u_nim.read_word(out_slot_base, d, vh);
    check("cmd_word0", d, w0);
    u_nim.read_word(out_slot_base + 16'h1, d, vh);
    check("cmd_word1", d, w1);
    check("pin4_drive", {8'h00, pin4_drive}, {8'h00, w0[7:0] & pin4_is_output});
    check("pin2_drive", {8'h00, pin2_drive},
          {8'h00, w1[7:0] & pin2_is_output & ~pin2_diag_en});
  endtask : check_cmds
  initial begin
    #(40 * 20000);
    fails++;
    stop_test;
  end
  initial begin
    repeat (10) @(posedge core_clk);
    sys_rst <= 1'b0;
    u_nim.set_node(16'h0005);
    check_cmds(16'h0000, 16'h0000);
    for (int c = 0; c < 3; c++) begin
      @(posedge core_clk);
      {pin4_is_output, pin2_diag_en, pin2_is_output} <= tab[c][95:72];
      {pin4_level, pin2_level, common_fault, supply_short, pin4_short,
       pin2_short, pin4_warn, pin2_warn} <= tab[c][71:0];
      repeat (4) @(posedge core_clk);
      for (int i = 0; i < 8; i++) begin
        u_nim.read_word(in_slot_base + 16'(i), d, vh);
        check("in_word", d, exp_in(i));
        check("in_hit", {14'h0000, vh}, 16'h0003);
      end
      check("red_led", {8'h00, red_led}, {8'h00, ~pin2_level & pin2_diag_en});
      wv = 16'ha5c3 + 16'(c) * 16'h1111;
      u_nim.write_word(out_slot_base, wv);
      u_nim.write_word(out_slot_base + 16'h1, ~wv);
      repeat (2) @(posedge core_clk);
      check_cmds(wv, ~wv);
    end
    u_nim.write_word(in_slot_base + 16'h2, 16'hffff);
    u_nim.write_word(out_slot_base + 16'h2, 16'hffff);
    u_nim.read_word(in_slot_base + 16'h2, d, vh);
    check("ro_word", d, exp_in(2));
    check_cmds(wv, ~wv);
    foreach (tab[k]) begin
      u_nim.read_word(k == 0 ? out_slot_base + 16'h2 : k == 1 ? in_slot_base + 16'h8
                      : in_slot_base - 16'h1, d, vh);
      check("unmapped", d, 16'h0000);
      check("unmapped_vh", {14'h0000, vh}, 16'h0002);
    end
    u_nim.set_node(16'd511);
    #1 check("slot_ok_in", {15'h0000, slot_ok}, 16'h0001);
    u_nim.set_node(16'd512);
    #1 check("slot_ok_out", {15'h0000, slot_ok}, 16'h0000);
    u_nim.read_word(in_slot_base, d, vh);
    check("outside", d, 16'h0000);
    check("outside_vh", {14'h0000, vh}, 16'h0002);
    @(posedge core_clk);
    sys_rst <= 1'b1;
    repeat (3) @(posedge core_clk);
    sys_rst <= 1'b0;
    u_nim.set_node(16'h0005);
    check_cmds(16'h0000, 16'h0000);
    stop_test;
  end
endmodule : spi_image_map_tb_top

// [dv/spi_nim_model.sv]
/*
  Island interface module model: slot placement from a node number,
  word reads and writes into the splitter image.
  Assumes the image module's read and write strobe ports on core_clk.
*/
module spi_nim_model (
  input  wire logic        core_clk,      // Clock
  output logic      [15:0] in_slot_base,  // First input word
  output logic      [15:0] out_slot_base, // First output word
  output logic             rd_en,         // Read strobe
  output logic      [15:0] rd_addr,       // Read word number
  input  wire logic [15:0] rd_data,       // Read word
  input  wire logic        rd_valid,      // Read answer
  input  wire logic        rd_hit,        // Address was ours
  output logic             wr_en,         // Write strobe
  output logic      [15:0] wr_addr,       // Write word number
  output logic      [15:0] wr_data        // Write word
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    {in_slot_base, out_slot_base, rd_en, rd_addr} = '0;
    {wr_en, wr_addr, wr_data} = '0;
  end
  task automatic set_node(input logic [15:0] node);
    @(posedge core_clk);
    in_slot_base  <= 16'hb150 + (node << 3);
    out_slot_base <= 16'h9c41 + (node << 1);
    @(posedge core_clk);
  endtask : set_node
  task automatic read_word(input logic [15:0] a, output logic [15:0] d, output logic [1:0] vh);
    @(posedge core_clk);
    rd_en   <= 1'b1;
    rd_addr <= a;
    @(posedge core_clk);
    rd_en   <= 1'b0;
    rd_addr <= ~a;
    @(posedge core_clk);
    d  = rd_data;
    vh = {rd_valid, rd_hit};
  endtask : read_word
  task automatic write_word(input logic [15:0] a, input logic [15:0] d);
    @(posedge core_clk);
    wr_en   <= 1'b1;
    wr_addr <= a;
    wr_data <= d;
    @(posedge core_clk);
    wr_en   <= 1'b0;
    wr_addr <= ~a;
    wr_data <= ~d;
  endtask : write_word
endmodule : spi_nim_model
